// ==== ofc_map.svh ====
/*
 register offsets, field positions, reset values and timing counts of the
 output fault and oring control block; assumes a 200 MHz system clock
*/
`ifndef OFC_MAP_SVH
`define OFC_MAP_SVH
`define OFC_CLK_MHZ          200
`define OFC_RETRY_MS         1000
`define OFC_RETRY_CYC        (`OFC_RETRY_MS * 1000 * `OFC_CLK_MHZ)
`define OFC_CONT_MV          100
`define OFC_REG_CTRL         4'h0
`define OFC_REG_OVTH         4'h1
`define OFC_REG_UVTH         4'h2
`define OFC_REG_ORTH         4'h3
`define OFC_REG_REVTH        4'h4
`define OFC_REG_LLTH         4'h5
`define OFC_REG_LLHYS        4'h6
`define OFC_REG_STAT         4'h7
`define OFC_REG_IRQ          4'h8
`define OFC_REG_MASK         4'h9
`define OFC_REG_COEFL        4'hA
`define OFC_REG_COEFH        4'hB
`define OFC_REG_ACTCOEF      4'hC
`define OFC_REG_SETPT        4'hD
`define OFC_CTRL_UVLATCH     0
`define OFC_CTRL_OVLATCH     1
`define OFC_CTRL_CONTEN      2
`define OFC_CTRL_OCDIS       3
`define OFC_CTRL_UVDIS       4
`define OFC_CTRL_RECTDIS     5
`define OFC_CTRL_RST         32'h0000_0000
`define OFC_IRQ_UV           0
`define OFC_IRQ_OVL          1
`define OFC_IRQ_OVR          2
`define OFC_IRQ_CONT         3
`define OFC_IRQ_LL           4
`define OFC_IRQ_REV          5
`define OFC_NIRQ             6
`endif

// ==== ofc_pkg.sv ====
/*
 types of the output fault and oring control block; no assumptions
*/
package ofc_pkg;
   typedef enum logic [2:0] {
      OFC_RUN   = 3'b001,
      OFC_RETRY = 3'b010,
      OFC_LATCH = 3'b100
   } ofc_state_type;
   typedef logic [15:0] ofc_mv_type;
endpackage

// ==== ofc_retry.sv ====
/*
 fault response engine for one fault class: timed retry or latch-off;
 assumes synchronous active-high reset and a flag level from the caller
*/
`timescale 1ns/1ps
`include "ofc_map.svh"
module ofc_retry
   import ofc_pkg::*;
#(
   parameter int unsigned RETRY_CYC = `OFC_RETRY_CYC
) (
   input  wire logic sys_clk,      // system clock
   input  wire logic rst,          // sync reset
   input  wire logic faultFlag,    // fault condition level
   input  wire logic latchMode,    // 1 latch, 0 timed retry
   input  wire logic supplyOnRise, // supply on request rising edge
   output logic      outEnable     // output allowed
);
   ofc_state_type stateR, stateNxt;
   logic [31:0]   cntR, cntNxt;

   always_comb begin
      stateNxt = stateR;
      cntNxt   = cntR;
      case (stateR)
         OFC_RUN: begin
            if (faultFlag) begin
               stateNxt = latchMode ? OFC_LATCH : OFC_RETRY;
               cntNxt   = 32'h0000_0000;
            end
         end
         OFC_RETRY: begin
            if (faultFlag)
               cntNxt = 32'h0000_0000;
            else if (cntR >= RETRY_CYC - 1)
               stateNxt = OFC_RUN;
            else
               cntNxt = cntR + 32'h0000_0001;
         end
         OFC_LATCH: begin
            if (supplyOnRise && !faultFlag)
               stateNxt = OFC_RUN;
         end
         default: stateNxt = OFC_RUN;
      endcase
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         stateR <= OFC_RUN;
         cntR   <= 32'h0000_0000;
      end else begin
         stateR <= stateNxt;
         cntR   <= cntNxt;
      end
   end

   assign outEnable = (stateR == OFC_RUN);

   AST_LATCH_HOLDS: assert property (@(posedge sys_clk) disable iff (rst)
      (stateR == OFC_LATCH && !supplyOnRise) |=> stateR == OFC_LATCH)
      else $error("latched fault released without supply on request");
   AST_RETRY_RESTART: assert property (@(posedge sys_clk) disable iff (rst)
      (stateR == OFC_RETRY && faultFlag) |=> cntR == 32'h0000_0000)
      else $error("retry counter not restarted by fault");
   AST_RETRY_FLAG_ZERO: assert property (@(posedge sys_clk) disable iff (rst)
      ($past(stateR) == OFC_RETRY && stateR == OFC_RUN) |-> !$past(faultFlag))
      else $error("retry ended while fault present");
endmodule

// ==== ofc_core.sv ====
/*
 output fault and oring control: voltage faults, retry or latch, continuity,
 light-load mode, coefficient select and oring gate drive, Avalon-MM slave;
 assumes sense values in mV/mA synchronous to sys_clk
*/
// The register addresses and register access over Avalon-MM are this design's own decisions.
`timescale 1ns/1ps
`include "ofc_map.svh"
module ofc_core
   import ofc_pkg::*;
#(
   parameter int unsigned RETRY_CYC = `OFC_RETRY_CYC
) (
   input  wire logic        sys_clk,            // system clock
   input  wire logic        rst,                // sync reset
   input  wire logic [3:0]  avs_address,        // word address
   input  wire logic        avs_read,           // read strobe
   input  wire logic        avs_write,          // write strobe
   input  wire logic [31:0] avs_writedata,      // write data
   input  wire logic [3:0]  avs_byteenable,     // byte lanes
   output logic [31:0]      avs_readdata,       // read data
   output logic             avs_waitrequest,    // stall
   input  wire logic [15:0] sensePointPreSwitch, // mV ahead of switch
   input  wire logic [15:0] sensePointPostSwitch,// mV after switch
   input  wire logic [15:0] sensePointLoad,     // mV at load
   input  wire logic [15:0] outputCurrentSense, // mA, forward
   input  wire logic [15:0] reverseCurrentSense,// mA, reverse
   input  wire logic        primaryFastOc,      // fast primary overcurrent
   input  wire logic        rectifiedNodeSense, // rectified node flag
   input  wire logic        supplyOnRequest,    // supply on request pin
   output logic             oringSwitchGate,    // oring switch gate drive
   output logic             rectifierEnable,    // synchronous rectifier drive enable
   output logic             supplyEnable,       // power stage enable
   output logic             lightLoadFlag,      // light-load mode
   output logic             rectOffFlag,        // rectifiers off
   output logic [31:0]      filterCoef,         // active compensation set
   output logic             irq                 // level interrupt
);
   logic [31:0] ctrlR, ctrlNxt;
   ofc_mv_type ovThR, ovThNxt, uvThR, uvThNxt, orThR, orThNxt, setPtR, setPtNxt;
   ofc_mv_type revThR, revThNxt, llThR, llThNxt, llHysR, llHysNxt;
   logic [31:0] coefLR, coefLNxt, coefHR, coefHNxt;
   logic [`OFC_NIRQ-1:0] irqR, irqNxt, maskR, maskNxt;
   logic [31:0] rdR, rdNxt;
   logic        ackR, ackNxt;
   logic        llR, llNxt, gateR, gateNxt, supOnR;
   logic [31:0] coefR;

   function automatic logic [31:0] wmask(input logic [31:0] old,
                                         input logic [31:0] val,
                                         input logic [3:0]  be);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++)
         if (be[i]) r[i*8 +: 8] = val[i*8 +: 8];
      return r;
   endfunction

   function automatic logic drop(input ofc_mv_type a, input ofc_mv_type b);
      return (a > b) && ((a - b) > 16'(`OFC_CONT_MV));
   endfunction

   // fault detection
   logic ovLocal, ovRemote, ovFlag, uvFlag, contFlag, revFlag, supplyOnRise;
   assign ovLocal  = (sensePointPreSwitch > ovThR) || (sensePointPostSwitch > ovThR);
   assign ovRemote = sensePointLoad > ovThR;
   assign ovFlag   = ovLocal || ovRemote || (setPtR > ovThR);
   assign uvFlag   = sensePointPreSwitch < uvThR;
   assign contFlag = ctrlR[`OFC_CTRL_CONTEN] &&
                     (drop(sensePointPreSwitch, sensePointPostSwitch) ||
                      drop(sensePointPostSwitch, sensePointLoad));
   assign revFlag  = reverseCurrentSense > revThR;
   assign supplyOnRise = supplyOnRequest && !supOnR;

   logic uvEn, ovEn;
   ofc_retry #(.RETRY_CYC(RETRY_CYC)) uUv (
      .sys_clk      (sys_clk),
      .rst          (rst),
      .faultFlag    (uvFlag),
      .latchMode    (ctrlR[`OFC_CTRL_UVLATCH]),
      .supplyOnRise (supplyOnRise),
      .outEnable    (uvEn)
   );
   ofc_retry #(.RETRY_CYC(RETRY_CYC)) uOv (
      .sys_clk      (sys_clk),
      .rst          (rst),
      .faultFlag    (ovFlag),
      .latchMode    (ctrlR[`OFC_CTRL_OVLATCH]),
      .supplyOnRise (supplyOnRise),
      .outEnable    (ovEn)
   );

   // light load with hysteresis and oring gate
   always_comb begin
      llNxt = llR;
      if (llThR == 16'h0000)
         llNxt = 1'b0;
      else if (!llR && outputCurrentSense < llThR)
         llNxt = 1'b1;
      else if (llR && outputCurrentSense >= 17'(llThR) + 17'(llHysR))
         llNxt = 1'b0;
      gateNxt = gateR;
      if (ovRemote || revFlag ||
          (ctrlR[`OFC_CTRL_OCDIS] && primaryFastOc) ||
          (ctrlR[`OFC_CTRL_UVDIS] && uvFlag) ||
          (ctrlR[`OFC_CTRL_RECTDIS] && llR && rectifiedNodeSense) ||
          !supplyEnable)
         gateNxt = 1'b0;
      else if (!gateR && (sensePointPreSwitch >= 17'(sensePointPostSwitch) + 17'(orThR)))
         gateNxt = 1'b1;
   end

   // register bus
   always_comb begin
      ctrlNxt = ctrlR;   ovThNxt = ovThR;   uvThNxt = uvThR;   orThNxt = orThR;
      revThNxt = revThR; llThNxt = llThR;   llHysNxt = llHysR; setPtNxt = setPtR;
      coefLNxt = coefLR; coefHNxt = coefHR; maskNxt = maskR;
      irqNxt = irqR;
      rdNxt  = rdR;
      ackNxt = 1'b0;
      if (avs_read || avs_write) begin
         ackNxt = !ackR;
         // a write lands at the edge where waitrequest is seen low
         if (avs_write && ackR) begin
            case (avs_address)
               `OFC_REG_CTRL:  ctrlNxt = wmask(ctrlR, avs_writedata, avs_byteenable);
               `OFC_REG_OVTH:  ovThNxt = 16'(wmask({16'h0, ovThR}, avs_writedata, avs_byteenable));
               `OFC_REG_UVTH:  uvThNxt = 16'(wmask({16'h0, uvThR}, avs_writedata, avs_byteenable));
               `OFC_REG_ORTH:  orThNxt = 16'(wmask({16'h0, orThR}, avs_writedata, avs_byteenable));
               `OFC_REG_REVTH: revThNxt = 16'(wmask({16'h0, revThR}, avs_writedata, avs_byteenable));
               `OFC_REG_LLTH:  llThNxt = 16'(wmask({16'h0, llThR}, avs_writedata, avs_byteenable));
               `OFC_REG_LLHYS: llHysNxt = 16'(wmask({16'h0, llHysR}, avs_writedata, avs_byteenable));
               `OFC_REG_SETPT: setPtNxt = 16'(wmask({16'h0, setPtR}, avs_writedata, avs_byteenable));
               `OFC_REG_COEFL: coefLNxt = wmask(coefLR, avs_writedata, avs_byteenable);
               `OFC_REG_COEFH: coefHNxt = wmask(coefHR, avs_writedata, avs_byteenable);
               `OFC_REG_MASK:  maskNxt = avs_writedata[`OFC_NIRQ-1:0];
               `OFC_REG_IRQ:   irqNxt = irqR & ~avs_writedata[`OFC_NIRQ-1:0];
               default: ;
            endcase
         end else if (avs_read && !ackR) begin
            case (avs_address)
               `OFC_REG_CTRL:    rdNxt = ctrlR;
               `OFC_REG_OVTH:    rdNxt = {16'h0, ovThR};
               `OFC_REG_UVTH:    rdNxt = {16'h0, uvThR};
               `OFC_REG_ORTH:    rdNxt = {16'h0, orThR};
               `OFC_REG_REVTH:   rdNxt = {16'h0, revThR};
               `OFC_REG_LLTH:    rdNxt = {16'h0, llThR};
               `OFC_REG_LLHYS:   rdNxt = {16'h0, llHysR};
               `OFC_REG_SETPT:   rdNxt = {16'h0, setPtR};
               `OFC_REG_COEFL:   rdNxt = coefLR;
               `OFC_REG_COEFH:   rdNxt = coefHR;
               `OFC_REG_ACTCOEF: rdNxt = coefR;
               `OFC_REG_MASK:    rdNxt = {26'h0, maskR};
               `OFC_REG_IRQ:     rdNxt = {26'h0, irqR};
               `OFC_REG_STAT:    rdNxt = {22'h0, gateR, llR, uvEn, ovEn, contFlag,
                                          revFlag, ovRemote, ovLocal, ovFlag, uvFlag};
               default:          rdNxt = 32'h0000_0000;
            endcase
         end
      end
      // set wins over clear
      irqNxt = irqNxt | {revFlag, llR, contFlag, ovRemote, ovLocal, uvFlag};
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         ctrlR <= `OFC_CTRL_RST;
         ovThR <= 16'hFFFF;  uvThR <= 16'h0000;  orThR <= 16'h0000;
         revThR <= 16'hFFFF; llThR <= 16'h0000;  llHysR <= 16'h0000;
         setPtR <= 16'h0000;
         coefLR <= 32'h0000_0000; coefHR <= 32'h0000_0000;
         irqR <= '0;  maskR <= '0;
         rdR <= 32'h0000_0000; ackR <= 1'b0;
         llR <= 1'b0; gateR <= 1'b0; supOnR <= 1'b1; // a request held through reset is no rise
         coefR <= 32'h0000_0000;
      end else begin
         ctrlR <= ctrlNxt;  ovThR <= ovThNxt;  uvThR <= uvThNxt;  orThR <= orThNxt;
         revThR <= revThNxt; llThR <= llThNxt; llHysR <= llHysNxt; setPtR <= setPtNxt;
         coefLR <= coefLNxt; coefHR <= coefHNxt;
         irqR <= irqNxt; maskR <= maskNxt;
         rdR <= rdNxt; ackR <= ackNxt;
         llR <= llNxt; gateR <= gateNxt; supOnR <= supplyOnRequest;
         coefR <= llNxt ? coefLR : coefHR;
      end
   end

   assign avs_waitrequest = (avs_read || avs_write) && !ackR;
   assign avs_readdata    = rdR;
   assign supplyEnable    = uvEn && ovEn;
   assign oringSwitchGate = gateR;
   assign rectifierEnable = !llR;
   assign lightLoadFlag   = llR;
   assign rectOffFlag     = llR;
   assign filterCoef      = coefR;
   assign irq             = |(irqR & maskR);

   AST_REMOTE_OV_GATE: assert property (@(posedge sys_clk) disable iff (rst)
      ovRemote |=> !oringSwitchGate)
      else $error("gate on during load overvoltage");
   AST_REV_GATE: assert property (@(posedge sys_clk) disable iff (rst)
      revFlag |=> !oringSwitchGate)
      else $error("gate on during reverse current");
   AST_GATE_ON_COND: assert property (@(posedge sys_clk) disable iff (rst)
      $rose(oringSwitchGate) |->
      $past(sensePointPreSwitch >= 17'(sensePointPostSwitch) + 17'(orThR)))
      else $error("gate turned on below threshold");
   AST_UV_DIS: assert property (@(posedge sys_clk) disable iff (rst)
      (ctrlR[`OFC_CTRL_UVDIS] && uvFlag) |=> !oringSwitchGate)
      else $error("gate on with undervoltage disable");
   AST_OV_FLAG: assert property (@(posedge sys_clk) disable iff (rst)
      (setPtR > ovThR) |-> ovFlag)
      else $error("set point above threshold without flag");
   AST_CONT: assert property (@(posedge sys_clk) disable iff (rst)
      (ctrlR[`OFC_CTRL_CONTEN] &&
       sensePointPreSwitch > 17'(sensePointPostSwitch) + 17'(`OFC_CONT_MV))
      |-> contFlag)
      else $error("continuity drop missed");
   AST_LL_ZERO: assert property (@(posedge sys_clk) disable iff (rst)
      (llThR == 16'h0000) |=> rectifierEnable)
      else $error("rectifiers off with zero threshold");
   AST_LL_COEF: assert property (@(posedge sys_clk) disable iff (rst)
      (lightLoadFlag && $stable(coefLR)) |-> filterCoef == coefLR)
      else $error("light load without light coefficients");
   AST_OV_SUPPLY: assert property (@(posedge sys_clk) disable iff (rst)
      ovFlag |=> !supplyEnable)
      else $error("supply stays on during overvoltage");
   COV_LL: cover property (@(posedge sys_clk) disable iff (rst) $rose(lightLoadFlag));
   COV_GATE: cover property (@(posedge sys_clk) disable iff (rst) $rose(oringSwitchGate));
   COV_UV: cover property (@(posedge sys_clk) disable iff (rst) $fell(uvEn));
   COV_IRQ: cover property (@(posedge sys_clk) disable iff (rst) $rose(irq));
endmodule

// ==== ofc_stage_model.sv ====
/*
 power stage model: local rail, oring switch, shared bus and load behind the sense inputs;
 assumes the bench sets rail, bus, drop and load knobs synchronous to sys_clk
*/
`timescale 1ns/1ps
module ofc_stage_model (
   input  wire logic        sys_clk,  // system clock
   input  wire logic        gateOn,   // oring switch gate drive
   input  wire logic [15:0] railMv,   // local rail ahead of the switch
   input  wire logic [15:0] busMv,    // shared bus, 0 when absent
   input  wire logic [15:0] dropMv,   // drop from switch to load
   input  wire logic [15:0] loadMa,   // load demand
   output logic      [15:0] preMv,    // sense ahead of switch
   output logic      [15:0] postMv,   // sense after switch
   output logic      [15:0] loadMv,   // sense at load
   output logic      [15:0] fwdMa,    // forward current
   output logic      [15:0] revMa     // reverse current
);
   logic [15:0] postNow;
   // a closed switch ties its far side to the rail, an open one leaves the bus
   assign postNow = gateOn ? railMv : busMv;
   always_ff @(posedge sys_clk) begin
      preMv  <= railMv;
      postMv <= postNow;
      loadMv <= (busMv > postNow) ? busMv : postNow - dropMv;
      fwdMa  <= gateOn ? loadMa : 16'h0000;
      revMa  <= (gateOn && busMv > railMv) ? busMv - railMv : 16'h0000;
   end
endmodule

// ==== ofc_core_tb_top.sv ====
/*
 self-checking bench of the output fault and oring control block;
 assumes ofc_core with a shortened retry count and the power stage model
*/
`timescale 1ns/1ps
`include "ofc_map.svh"
module ofc_core_tb_top;
   localparam int          RETRY = 50;
   localparam int          LIMIT = 20000;
   localparam logic [31:0] COEFL = 32'hA5A5_0001;
   localparam logic [31:0] COEFH = 32'h5A5A_0002;
   typedef struct {
      logic [15:0] rail, bus, ma;
      logic        gate, rectEn, ll;
   } ofc_row_type;
   logic        sys_clk, rst, avsRead, avsWrite, waitReq, oc, rectNode, supplyOn;
   logic        gate, rectEn, supplyEn, llFlag, rectOff, irq;
   logic [3:0]  avsAddr;
   logic [31:0] avsWdata, rdata, coef, rv;
   logic [15:0] railMv, busMv, dropMv, loadMa, preMv, postMv, loadMv, fwdMa, revMa;
   int          n_mismatch, samples_checked, cycles, n;
   logic [35:0] cfg [10];
   ofc_row_type rows [7];

   ofc_core #(.RETRY_CYC(RETRY)) ofc_core_i (
      .sys_clk(sys_clk), .rst(rst), .avs_address(avsAddr), .avs_read(avsRead),
      .avs_write(avsWrite), .avs_writedata(avsWdata), .avs_byteenable(4'hF),
      .avs_readdata(rdata), .avs_waitrequest(waitReq), .sensePointPreSwitch(preMv),
      .sensePointPostSwitch(postMv), .sensePointLoad(loadMv), .outputCurrentSense(fwdMa),
      .reverseCurrentSense(revMa), .primaryFastOc(oc), .rectifiedNodeSense(rectNode),
      .supplyOnRequest(supplyOn), .oringSwitchGate(gate), .rectifierEnable(rectEn),
      .supplyEnable(supplyEn), .lightLoadFlag(llFlag), .rectOffFlag(rectOff),
      .filterCoef(coef), .irq(irq));
   ofc_stage_model ofc_stage_model_i (
      .sys_clk(sys_clk), .gateOn(gate), .railMv(railMv), .busMv(busMv), .dropMv(dropMv),
      .loadMa(loadMa), .preMv(preMv), .postMv(postMv), .loadMv(loadMv), .fwdMa(fwdMa),
      .revMa(revMa));

   initial begin
      sys_clk = 1'b0;
      forever #2.5 sys_clk = ~sys_clk;
   end
   always @(posedge sys_clk) begin
      cycles <= cycles + 1;
      if (cycles == LIMIT) begin
         n_mismatch++;
         final_report();
      end
   end

   task automatic final_report();
      $display("checks %0d, mismatches %0d", samples_checked, n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("unexpected %s: expected %h, seen %h", what, exp, seen);
      end
   endtask
   // one Avalon transfer, held until waitrequest is seen low at a rising edge
   task automatic bus_op(input logic wr, input logic [3:0] addr, input logic [31:0] wdata);
      int k;
      k = 0;
      @(posedge sys_clk);
      avsAddr <= addr;
      avsWdata <= wdata;
      avsRead <= !wr;
      avsWrite <= wr;
      do begin
         @(negedge sys_clk);
         k++;
      end while (waitReq !== 1'b0 && k < 100);
      @(posedge sys_clk);
      rv = rdata;
      avsRead <= 1'b0;
      avsWrite <= 1'b0;
      if (k >= 100) n_mismatch++;
   endtask
   task automatic stage(input logic [15:0] rail, bus, drop, ma);
      @(posedge sys_clk);
      railMv <= rail;
      busMv <= bus;
      dropMv <= drop;
      loadMa <= ma;
   endtask
   function automatic logic pick(input int sel);
      case (sel)
         0: pick = gate;
         1: pick = supplyEn;
         2: pick = irq;
         default: pick = llFlag;
      endcase
   endfunction
   // bounded wait for an output level, then compare it
   task automatic expect_sig(input string what, input int sel, input logic val, input int maxc);
      n = 0;
      // let the edge that may launch the output settle before looking
      @(negedge sys_clk);
      while (pick(sel) !== val && n < maxc) begin
         @(negedge sys_clk);
         n++;
      end
      check(what, pick(sel), val);
   endtask

   initial begin
      rst = 1'b1;
      avsRead = 1'b0;
      avsWrite = 1'b0;
      avsAddr = 4'h0;
      avsWdata = 32'h0000_0000;
      oc = 1'b0;
      rectNode = 1'b0;
      supplyOn = 1'b1;
      railMv = 16'h2EE0;
      busMv = 16'h0000;
      dropMv = 16'h0000;
      loadMa = 16'h1388;
      cfg = '{{`OFC_REG_OVTH, 32'h0000_32C8}, {`OFC_REG_UVTH, 32'h0000_2328},
              {`OFC_REG_ORTH, 32'h0000_0032}, {`OFC_REG_REVTH, 32'h0000_01F4},
              {`OFC_REG_LLTH, 32'h0000_03E8}, {`OFC_REG_LLHYS, 32'h0000_00C8},
              {`OFC_REG_COEFL, COEFL}, {`OFC_REG_COEFH, COEFH},
              {`OFC_REG_SETPT, 32'h0000_2EE0}, {`OFC_REG_MASK, 32'h0000_003F}};
      rows = '{'{16'h2EE0, 16'h0000, 16'h1388, 1'b1, 1'b1, 1'b0},
               '{16'h2EE0, 16'h0000, 16'h01F4, 1'b1, 1'b0, 1'b1},
               '{16'h2EE0, 16'h0000, 16'h044C, 1'b1, 1'b0, 1'b1},
               '{16'h2EE0, 16'h0000, 16'h04B0, 1'b1, 1'b1, 1'b0},
               '{16'h2EE0, 16'h30D4, 16'h1388, 1'b1, 1'b1, 1'b0},
               '{16'h2EE0, 16'h3138, 16'h1388, 1'b0, 1'b0, 1'b1},
               '{16'h2EE0, 16'h0000, 16'h1388, 1'b1, 1'b1, 1'b0}};
      repeat (7) @(negedge sys_clk);
      check("reset gate", gate, 1'b0);
      check("reset supply", supplyEn, 1'b1);
      check("reset rectifier", rectEn, 1'b1);
      check("reset irq", irq, 1'b0);
      check("reset wait", waitReq, 1'b0);
      @(posedge sys_clk);
      rst <= 1'b0;
      bus_op(1'b0, `OFC_REG_CTRL, 32'h0);
      check("ctrl reset", rv, `OFC_CTRL_RST);
      foreach (cfg[i]) bus_op(1'b1, cfg[i][35:32], cfg[i][31:0]);
      bus_op(1'b0, 4'hF, 32'h0);
      check("unmapped read", rv, 32'h0);
      bus_op(1'b0, `OFC_REG_COEFL, 32'h0);
      check("light coef", rv, COEFL);
      expect_sig("supply up", 1, 1'b1, 200);
      expect_sig("gate up", 0, 1'b1, 200);
      foreach (rows[i]) begin
         stage(rows[i].rail, rows[i].bus, 16'h0, rows[i].ma);
         expect_sig("row gate", 0, rows[i].gate, 40);
         repeat (4) @(negedge sys_clk);
         check("row gate held", gate, rows[i].gate);
         check("rectifier", rectEn, !rows[i].ll);
         check("light flag", llFlag, rows[i].ll);
         check("rect off", rectOff, rows[i].ll);
         check("coef", coef, rows[i].ll ? COEFL : COEFH);
      end
      bus_op(1'b0, `OFC_REG_ACTCOEF, 32'h0);
      check("active coef", rv, COEFH);
      bus_op(1'b1, `OFC_REG_CTRL, 32'h0000_0004);
      stage(16'h2EE0, 16'h0000, 16'h0064, 16'h1388);
      repeat (4) @(negedge sys_clk);
      bus_op(1'b1, `OFC_REG_IRQ, 32'h0000_003F);
      repeat (4) @(negedge sys_clk);
      check("drop 100 irq", irq, 1'b0);
      stage(16'h2EE0, 16'h0000, 16'h0065, 16'h1388);
      expect_sig("drop 101 irq", 2, 1'b1, 10);
      bus_op(1'b0, `OFC_REG_IRQ, 32'h0);
      check("drop 101 bit", rv[`OFC_IRQ_CONT], 1'b1);
      stage(16'h2EE0, 16'h0000, 16'h0000, 16'h1388);
      bus_op(1'b1, `OFC_REG_CTRL, 32'h0);
      bus_op(1'b1, `OFC_REG_SETPT, 32'h0000_36B0);
      expect_sig("setpoint ov", 1, 1'b0, 20);
      bus_op(1'b1, `OFC_REG_SETPT, 32'h0000_2EE0);
      expect_sig("setpoint retry", 1, 1'b1, 200);
      stage(16'h34BC, 16'h0000, 16'h0000, 16'h1388);
      expect_sig("local ov", 1, 1'b0, 20);
      bus_op(1'b0, `OFC_REG_IRQ, 32'h0);
      check("local ov bit", rv[`OFC_IRQ_OVL], 1'b1);
      repeat (2 * RETRY) @(negedge sys_clk);
      check("no retry in fault", supplyEn, 1'b0);
      stage(16'h2EE0, 16'h0000, 16'h0000, 16'h1388);
      expect_sig("ov retry", 1, 1'b1, 200);
      check("retry time", (n >= RETRY - 2 && n <= RETRY + 8), 1'b1);
      bus_op(1'b1, `OFC_REG_CTRL, 32'h0000_0002);
      stage(16'h34BC, 16'h0000, 16'h0000, 16'h1388);
      expect_sig("latch ov", 1, 1'b0, 20);
      stage(16'h2EE0, 16'h0000, 16'h0000, 16'h1388);
      repeat (3 * RETRY) @(negedge sys_clk);
      check("latched", supplyEn, 1'b0);
      @(posedge sys_clk);
      supplyOn <= 1'b0;
      repeat (4) @(posedge sys_clk);
      supplyOn <= 1'b1;
      expect_sig("latch cleared", 1, 1'b1, 20);
      bus_op(1'b1, `OFC_REG_CTRL, 32'h0);
      bus_op(1'b1, `OFC_REG_REVTH, 32'h0000_FFFF);
      expect_sig("gate before bus", 0, 1'b1, 200);
      stage(16'h2EE0, 16'h34BC, 16'h0000, 16'h1388);
      expect_sig("bus ov gate", 0, 1'b0, 20);
      bus_op(1'b0, `OFC_REG_IRQ, 32'h0);
      check("remote ov bit", rv[`OFC_IRQ_OVR], 1'b1);
      stage(16'h2EE0, 16'h0000, 16'h0000, 16'h1388);
      bus_op(1'b1, `OFC_REG_REVTH, 32'h0000_01F4);
      bus_op(1'b1, `OFC_REG_CTRL, 32'h0000_0010);
      expect_sig("gate before uv", 0, 1'b1, 200);
      bus_op(1'b1, `OFC_REG_IRQ, 32'h0000_003F);
      stage(16'h1F40, 16'h0000, 16'h0000, 16'h1388);
      expect_sig("uv gate", 0, 1'b0, 20);
      expect_sig("uv supply", 1, 1'b0, 20);
      expect_sig("uv irq", 2, 1'b1, 10);
      bus_op(1'b1, `OFC_REG_MASK, 32'h0);
      expect_sig("masked irq", 2, 1'b0, 4);
      bus_op(1'b1, `OFC_REG_MASK, 32'h0000_003F);
      expect_sig("unmasked irq", 2, 1'b1, 4);
      stage(16'h2EE0, 16'h0000, 16'h0000, 16'h1388);
      expect_sig("uv gate back", 0, 1'b1, 200);
      bus_op(1'b1, `OFC_REG_IRQ, 32'h0000_003F);
      expect_sig("cleared irq", 2, 1'b0, 4);
      bus_op(1'b1, `OFC_REG_CTRL, 32'h0000_0008);
      @(posedge sys_clk);
      oc <= 1'b1;
      expect_sig("fast oc gate", 0, 1'b0, 10);
      @(posedge sys_clk);
      oc <= 1'b0;
      expect_sig("fast oc gate back", 0, 1'b1, 200);
      bus_op(1'b1, `OFC_REG_CTRL, 32'h0000_0020);
      stage(16'h2EE0, 16'h0000, 16'h0000, 16'h01F4);
      expect_sig("light entry", 3, 1'b1, 10);
      @(posedge sys_clk);
      rectNode <= 1'b1;
      expect_sig("node gate", 0, 1'b0, 10);
      @(posedge sys_clk);
      rectNode <= 1'b0;
      expect_sig("node gate back", 0, 1'b1, 200);
      bus_op(1'b1, `OFC_REG_LLTH, 32'h0);
      stage(16'h2EE0, 16'h0000, 16'h0000, 16'h0000);
      expect_sig("zero threshold", 3, 1'b0, 10);
      repeat (6) @(negedge sys_clk);
      check("zero threshold rect", rectEn, 1'b1);
      bus_op(1'b1, `OFC_REG_CTRL, 32'h0000_0001);
      stage(16'h1F40, 16'h0000, 16'h0000, 16'h1388);
      expect_sig("uv latch", 1, 1'b0, 20);
      stage(16'h2EE0, 16'h0000, 16'h0000, 16'h1388);
      repeat (3 * RETRY) @(negedge sys_clk);
      check("uv latched", supplyEn, 1'b0);
      @(posedge sys_clk);
      supplyOn <= 1'b0;
      @(posedge sys_clk);
      supplyOn <= 1'b1;
      expect_sig("uv latch cleared", 1, 1'b1, 20);
      stage(16'h1F40, 16'h0000, 16'h0000, 16'h1388);
      expect_sig("uv relatch", 1, 1'b0, 20);
      @(posedge sys_clk);
      rst <= 1'b1;
      repeat (2) @(negedge sys_clk);
      check("mid reset gate", gate, 1'b0);
      check("mid reset supply", supplyEn, 1'b1);
      check("mid reset irq", irq, 1'b0);
      check("mid reset rectifier", rectEn, 1'b1);
      @(posedge sys_clk);
      rst <= 1'b0;
      bus_op(1'b0, `OFC_REG_UVTH, 32'h0);
      check("mid reset uv threshold", rv, 32'h0);
      final_report();
   end
endmodule
